// file: verilog/qd_pkg.sv
// constants and carrier types for the quad dac serial update control
package qd_pkg;
  // frame layout
  localparam int QD_FRAME_BITS = 24;
  localparam int QD_CHANNELS = 4;
  localparam int QD_BIT_RW = 23;
  localparam int QD_BIT_ZERO = 22;
  localparam int QD_SEL_HI = 21;
  localparam int QD_SEL_LO = 19;
  localparam int QD_ADR_HI = 18;
  localparam int QD_ADR_LO = 16;
  localparam logic [4:0] QD_LAST_BIT = 5'h17;
  // register select codes
  localparam logic [2:0] QD_SEL_FUNC = 3'h0;
  localparam logic [2:0] QD_SEL_DATA = 3'h2;
  localparam logic [2:0] QD_SEL_CGAIN = 3'h3;
  localparam logic [2:0] QD_SEL_FGAIN = 3'h4;
  localparam logic [2:0] QD_SEL_OFFS = 3'h5;
  // channel address and function codes
  localparam logic [2:0] QD_ADR_ALL = 3'h4;
  localparam logic [2:0] QD_FN_CTRL = 3'h1;
  localparam logic [2:0] QD_FN_CLEAR = 3'h4;
  localparam logic [2:0] QD_FN_LOAD = 3'h5;
  localparam int QD_FUNC_SDO_DIS = 0;
  // reset values and coding
  localparam logic [15:0] QD_ZERO_CODE = 16'h0000;
  localparam logic [15:0] QD_MSB_FLIP = 16'h8000;
  localparam logic [5:0] QD_FUNC_RESET = 6'h00;
  localparam logic QD_CTRL_RESET = 1'b1;
  // pin sampler lanes
  localparam int QD_PIN_SCLK = 0;
  localparam int QD_PIN_SYNC = 1;
  localparam int QD_PIN_SERIAL_IN = 2;
  localparam int QD_PIN_OUTPUT_LOAD_STROBE_N = 3;
  localparam int QD_PIN_CLR = 4;
  localparam int QD_PIN_COD = 5;
  // avalon byte offsets
  localparam logic [4:0] QD_OFF_STATUS = 5'h00;
  localparam logic [4:0] QD_OFF_CTRL = 5'h04;
  localparam logic [4:0] QD_OFF_CODE = 5'h10;

  typedef struct packed {
    logic [14:0] seg;
    logic [11:0] ladder;
  } qd_drive_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } qd_avs_req_t;

  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] syn;
    logic [5:0] prev;
    logic [23:0] shreg;
    logic [4:0] bit_cnt;
    logic wrapped;
    logic in_frame;
    logic [3:0][15:0] data_reg;
    logic [3:0][15:0] dac_reg;
    logic [3:0][1:0] cgain;
    logic [3:0][5:0] fgain;
    logic [3:0][15:0] offs;
    logic [5:0] func;
    logic clamp;
    logic serial_out;
    logic [7:0] inval_cnt;
    logic link_en;
    logic ack;
    logic [31:0] rdata;
    qd_drive_t [3:0] drv;
  } qd_state_t;
endpackage : qd_pkg

// file: verilog/qd_dac_ctrl.sv
// serial command port and output update control of a quad 16-bit dac
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps

module qd_dac_ctrl
  import qd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // serial link pins
  input wire logic i_serial_clk,
  input wire logic i_frame_sync_n,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  // update control pins
  input wire logic i_output_load_strobe_n,
  input wire logic i_output_clear_n,
  input wire logic i_coding_select,
  // converter drive
  output logic o_clamp,
  output qd_drive_t [3:0] o_drive,
  // avalon-mm slave
  input wire qd_avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  qd_state_t st_reg;
  qd_state_t st_next;

  function automatic logic [14:0] qd_thermo(input logic [3:0] nib);
    logic [14:0] t;
    t = '0;
    for (int i = 0; i < 15; i++) begin
      t[i] = ({1'b0, nib} > 5'(i));
    end
    return t;
  endfunction : qd_thermo

  // coding select low means twos complement
  function automatic qd_drive_t qd_conv(input logic [15:0] code,
                                        input logic offset_bin);
    logic [15:0] ob;
    qd_drive_t d;
    ob = offset_bin ? code : (code ^ QD_MSB_FLIP);
    d.seg = qd_thermo(ob[15:12]);
    d.ladder = ob[11:0];
    return d;
  endfunction : qd_conv

  function automatic logic [3:0] qd_chmask(input logic [2:0] adr);
    logic [3:0] m;
    m = 4'h0;
    if (adr == QD_ADR_ALL) begin
      m = 4'hf;
    end else if (!adr[2]) begin
      m[adr[1:0]] = 1'b1;
    end
    return m;
  endfunction : qd_chmask

  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;
  logic output_load_strobe_n_fall;
  logic clr_fall;
  logic frame_ok;
  logic rw;
  logic [2:0] sel;
  logic [2:0] adr;
  logic [15:0] dat;
  logic [3:0] mask;
  logic [1:0] rch;
  logic [15:0] rb_word;
  logic wr_data_now;
  logic clear_now;
  logic load_all_now;
  logic req_any;

  always_comb begin
    sclk_fall = st_reg.prev[QD_PIN_SCLK] & ~st_reg.syn[QD_PIN_SCLK];
    sclk_rise = ~st_reg.prev[QD_PIN_SCLK] & st_reg.syn[QD_PIN_SCLK];
    sync_fall = st_reg.prev[QD_PIN_SYNC] & ~st_reg.syn[QD_PIN_SYNC];
    sync_rise = ~st_reg.prev[QD_PIN_SYNC] & st_reg.syn[QD_PIN_SYNC];
    output_load_strobe_n_fall = st_reg.prev[QD_PIN_OUTPUT_LOAD_STROBE_N] & ~st_reg.syn[QD_PIN_OUTPUT_LOAD_STROBE_N];
    clr_fall = st_reg.prev[QD_PIN_CLR] & ~st_reg.syn[QD_PIN_CLR];
    // whole multiples of 24 clocks keep daisy chains working
    frame_ok = sync_rise & st_reg.in_frame & st_reg.wrapped &
               (st_reg.bit_cnt == 5'h00) &
               ~st_reg.shreg[QD_BIT_ZERO] & st_reg.link_en;
    rw = st_reg.shreg[QD_BIT_RW];
    sel = st_reg.shreg[QD_SEL_HI:QD_SEL_LO];
    adr = st_reg.shreg[QD_ADR_HI:QD_ADR_LO];
    dat = st_reg.shreg[15:0];
    mask = qd_chmask(adr);
    rch = adr[1:0];
    case (sel)
      QD_SEL_FUNC: rb_word = {10'h000, st_reg.func};
      QD_SEL_DATA: rb_word = st_reg.data_reg[rch];
      QD_SEL_CGAIN: rb_word = {14'h0000, st_reg.cgain[rch]};
      QD_SEL_FGAIN: rb_word = {10'h000, st_reg.fgain[rch]};
      QD_SEL_OFFS: rb_word = st_reg.offs[rch];
      default: rb_word = QD_ZERO_CODE;
    endcase
    wr_data_now = frame_ok & ~rw & (sel == QD_SEL_DATA);
    clear_now = clr_fall |
                (st_reg.clamp & ~st_reg.syn[QD_PIN_CLR]) |
                (frame_ok & ~rw & (sel == QD_SEL_FUNC) &
                 (adr == QD_FN_CLEAR));
    load_all_now = output_load_strobe_n_fall |
                   (frame_ok & ~rw & (sel == QD_SEL_FUNC) &
                    (adr == QD_FN_LOAD));
    req_any = i_avs.read | i_avs.write;
  end

  always_comb begin
    st_next = st_reg;
    st_next.meta = {i_coding_select, i_output_clear_n,
                    i_output_load_strobe_n, i_serial_in,
                    i_frame_sync_n, i_serial_clk};
    st_next.syn = st_reg.meta;
    st_next.prev = st_reg.syn;

    // link shifting
    if (sync_fall) begin
      st_next.in_frame = 1'b1;
      st_next.bit_cnt = 5'h00;
      st_next.wrapped = 1'b0;
      st_next.serial_out = st_reg.shreg[QD_BIT_RW];
    end else if (sync_rise) begin
      st_next.in_frame = 1'b0;
      if (st_reg.in_frame && !frame_ok) begin
        st_next.inval_cnt = st_reg.inval_cnt + 8'h01;
      end
    end else if (st_reg.in_frame && sclk_fall) begin
      st_next.shreg = {st_reg.shreg[22:0],
                       st_reg.syn[QD_PIN_SERIAL_IN]};
      if (st_reg.bit_cnt == QD_LAST_BIT) begin
        st_next.bit_cnt = 5'h00;
        st_next.wrapped = 1'b1;
      end else begin
        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      end
    end else if (st_reg.in_frame && sclk_rise) begin
      st_next.serial_out = st_reg.shreg[QD_BIT_RW];
    end

    // frame commit
    if (frame_ok) begin
      if (rw) begin
        st_next.shreg = {st_reg.shreg[23:16], rb_word};
      end else begin
        case (sel)
          QD_SEL_FUNC: begin
            if (adr == QD_FN_CTRL) begin
              st_next.func = dat[5:0];
            end
          end
          QD_SEL_DATA: begin
            for (int c = 0; c < QD_CHANNELS; c++) begin
              if (mask[c]) begin
                st_next.data_reg[c] = dat;
                if (!st_reg.syn[QD_PIN_OUTPUT_LOAD_STROBE_N]) begin
                  st_next.dac_reg[c] = dat;
                end
              end
            end
          end
          QD_SEL_CGAIN: begin
            for (int c = 0; c < QD_CHANNELS; c++) begin
              if (mask[c]) begin
                st_next.cgain[c] = dat[1:0];
              end
            end
          end
          QD_SEL_FGAIN: begin
            for (int c = 0; c < QD_CHANNELS; c++) begin
              if (mask[c]) begin
                st_next.fgain[c] = dat[5:0];
              end
            end
          end
          QD_SEL_OFFS: begin
            for (int c = 0; c < QD_CHANNELS; c++) begin
              if (mask[c]) begin
                st_next.offs[c] = dat;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end

    // update control; clear outranks any load
    if (clear_now) begin
      for (int c = 0; c < QD_CHANNELS; c++) begin
        st_next.data_reg[c] = QD_ZERO_CODE;
        st_next.dac_reg[c] = QD_ZERO_CODE;
      end
      st_next.clamp = 1'b0;
    end else if (load_all_now) begin
      st_next.dac_reg = st_next.data_reg;
      st_next.clamp = 1'b0;
    end

    // converter drive follows dac registers one cycle later
    for (int c = 0; c < QD_CHANNELS; c++) begin
      st_next.drv[c] = qd_conv(st_reg.dac_reg[c],
                               st_reg.syn[QD_PIN_COD]);
    end

    // avalon slave: one wait cycle, then the answer
    st_next.ack = req_any & ~st_reg.ack;
    if (req_any && !st_reg.ack) begin
      st_next.rdata = 32'h0000_0000;
      if (i_avs.address == QD_OFF_STATUS) begin
        st_next.rdata = {16'h0000, st_reg.inval_cnt, 4'h0,
                         st_reg.link_en, ~st_reg.func[QD_FUNC_SDO_DIS],
                         ~st_reg.syn[QD_PIN_COD], st_reg.clamp};
      end else if (i_avs.address == QD_OFF_CTRL) begin
        st_next.rdata = {31'h0000_0000, st_reg.link_en};
      end else if (i_avs.address[4] && i_avs.address[1:0] == 2'h0) begin
        st_next.rdata = {16'h0000, st_reg.dac_reg[i_avs.address[3:2]]};
      end
    end
    if (i_avs.write && st_reg.ack && i_avs.address == QD_OFF_CTRL) begin
      st_next.link_en = i_avs.writedata[0];
    end

    if (!i_rst_b) begin
      st_next = '0;
      st_next.meta = 6'h3f;
      st_next.syn = 6'h3f;
      st_next.prev = 6'h3f;
      for (int c = 0; c < QD_CHANNELS; c++) begin
        st_next.data_reg[c] = QD_ZERO_CODE;
        st_next.dac_reg[c] = QD_ZERO_CODE;
      end
      st_next.func = QD_FUNC_RESET;
      st_next.clamp = 1'b1;
      st_next.link_en = QD_CTRL_RESET;
    end
  end

  always_ff @(posedge i_mclk) begin
    st_reg <= st_next;
  end

  assign o_drive = st_reg.drv;
  assign o_clamp = st_reg.clamp;
  assign o_serial_out = st_reg.serial_out;
  assign o_serial_out_oe = ~st_reg.func[QD_FUNC_SDO_DIS];
  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = req_any & ~st_reg.ack;

  property p_reset_clamp;
    @(posedge i_mclk) !i_rst_b |=> st_reg.clamp &&
      st_reg.dac_reg[0] == 16'h0000 && st_reg.dac_reg[3] == 16'h0000;
  endproperty
  a_reset_clamp: assert property (p_reset_clamp)
    else $error("reset did not clamp with zero code");

  property p_shift_in;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (st_reg.in_frame && sclk_fall && !sync_rise && !sync_fall)
      |=> st_reg.shreg[0] == $past(st_reg.syn[QD_PIN_SERIAL_IN]) &&
          st_reg.shreg[23:1] == $past(st_reg.shreg[22:0]);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial bit not shifted in at falling clock");

  property p_bad_count;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (sync_rise && st_reg.in_frame && st_reg.bit_cnt != 5'h00)
      |=> st_reg.data_reg == $past(st_reg.data_reg) &&
          st_reg.inval_cnt == $past(st_reg.inval_cnt) + 8'h01;
  endproperty
  a_bad_count: assert property (p_bad_count)
    else $error("frame with wrong clock count was not dropped");

  property p_sdo_rise;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (st_reg.in_frame && sclk_rise && !sync_rise && !sync_fall)
      |=> o_serial_out == $past(st_reg.shreg[23]);
  endproperty
  a_sdo_rise: assert property (p_sdo_rise)
    else $error("serial output not updated on rising clock");

  property p_individual;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (wr_data_now && mask[0] && !st_reg.syn[QD_PIN_OUTPUT_LOAD_STROBE_N] && !clear_now)
      |=> st_reg.dac_reg[0] == $past(dat);
  endproperty
  a_individual: assert property (p_individual)
    else $error("addressed channel missed its update");

  property p_held;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (wr_data_now && st_reg.syn[QD_PIN_OUTPUT_LOAD_STROBE_N] && !clear_now
       && !load_all_now) |=> $stable(st_reg.dac_reg);
  endproperty
  a_held: assert property (p_held)
    else $error("output changed while load strobe high");

  property p_load_fall;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (output_load_strobe_n_fall && !clear_now && !frame_ok)
      |=> st_reg.dac_reg == $past(st_reg.data_reg) && !st_reg.clamp;
  endproperty
  a_load_fall: assert property (p_load_fall)
    else $error("load strobe fall did not update all channels");

  property p_clear;
    @(posedge i_mclk) disable iff (!i_rst_b)
      clear_now |=> st_reg.dac_reg == '0 && !st_reg.clamp
      ##1 st_reg.dac_reg == '0 || $past(load_all_now || frame_ok);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero the outputs");

  property p_readback;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (frame_ok && rw && !sync_fall)
      |=> st_reg.shreg[15:0] == $past(rb_word) &&
          $stable(st_reg.data_reg);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback word not loaded for shifting out");

  property p_decode;
    @(posedge i_mclk) disable iff (!i_rst_b)
      ##2 o_drive[1].ladder == $past(st_reg.dac_reg[1][11:0], 1) &&
      o_drive[1].seg[14] == ($past(st_reg.dac_reg[1][15:12], 1) ==
        ($past(st_reg.syn[QD_PIN_COD], 1) ? 4'hf : 4'h7));
  endproperty
  a_decode: assert property (p_decode)
    else $error("segment or ladder decode wrong");

  // a new frame must start from a clean count
  property p_frame_start;
    @(posedge i_mclk) disable iff (!i_rst_b)
      sync_fall |=> st_reg.in_frame && st_reg.bit_cnt == 5'h00 &&
        !st_reg.wrapped;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame sync fall did not open a frame");

endmodule : qd_dac_ctrl

// file: bench/qd_host_model.sv
// host side of the serial link: frame bursts and serial out capture
`timescale 1ns/10ps
module qd_host_model (
  // clock
  input wire logic i_mclk,
  // link
  input wire logic i_serial_out,
  output logic o_serial_clk,
  output logic o_frame_sync_n,
  output logic o_serial_in
);
  initial begin
    o_serial_clk = 1'b0;
    o_frame_sync_n = 1'b1;
    o_serial_in = 1'b0;
  end
  // 20 mclk a half period gives the 160 ns link clock
  task automatic half;
    repeat (20) @(posedge i_mclk);
  endtask : half
  // gated burst, msb first, clock still outside frames
  task automatic frame(input logic [47:0] w, input int n,
                       output logic [47:0] q);
    q = '0;
    @(posedge i_mclk);
    o_frame_sync_n <= 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_in <= w[i];
      o_serial_clk <= 1'b1;
      half();
      q = {q[46:0], i_serial_out}; // taken at the falling edge
      o_serial_clk <= 1'b0;
      half();
    end
    o_frame_sync_n <= 1'b1;
    // released data line must not keep its last level
    o_serial_in <= ~o_serial_in;
    half();
  endtask : frame
endmodule : qd_host_model

// file: bench/testbench.sv
// self-checking bench of the quad dac serial update control
`timescale 1ns/10ps
module testbench;
  import qd_pkg::*;
  logic mclk, rst_b, ldn, clrn, cod, sclk, sync_n, serial_in, so, so_oe, clamp, wr;
  qd_drive_t [3:0] drv;
  qd_avs_req_t req;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [47:0] sq;
  int err_total;
  int check_count;

  qd_dac_ctrl i_dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_serial_clk(sclk),
    .i_frame_sync_n(sync_n), .i_serial_in(serial_in), .o_serial_out(so),
    .o_serial_out_oe(so_oe), .i_output_load_strobe_n(ldn),
    .i_output_clear_n(clrn), .i_coding_select(cod), .o_clamp(clamp),
    .o_drive(drv), .i_avs(req), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wr));
  qd_host_model i_host (.i_mclk(mclk), .i_serial_out(so),
    .o_serial_clk(sclk), .o_frame_sync_n(sync_n), .o_serial_in(serial_in));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_n

  function automatic logic [4:0] adr(input int c);
    return QD_OFF_CODE | 5'(c * 4);
  endfunction : adr

  // expected decode, always offset-binary form before segmenting
  function automatic logic [47:0] exp_drv(input logic [15:0] c,
                                          input logic cb);
    logic [15:0] ob;
    qd_drive_t d;
    ob = cb ? c : c ^ QD_MSB_FLIP;
    for (int i = 0; i < 15; i++) d.seg[i] = (ob[15:12] > 4'(i));
    d.ladder = ob[11:0];
    return 48'(d);
  endfunction : exp_drv

  task automatic avs(input logic rd, input logic [4:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    req <= {rd, !rd, a, wd};
    do begin
      @(posedge mclk);
      n++;
    end while (wr !== 1'b0 && n < 64);
    q = rdat;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 64) begin
      err_total++;
      complete_run();
    end
  endtask : avs

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    avs(1'b1, a, 32'h0);
    chk(48'(q), 48'(e));
  endtask : rchk

  task automatic fr(input logic [47:0] w, input int n);
    i_host.frame(w, n, sq);
    wait_n(20);
  endtask : fr

  task automatic do_reset(input logic clr_lvl);
    @(posedge mclk);
    clrn <= clr_lvl;
    rst_b <= 1'b0;
    wait_n(6);
    rst_b <= 1'b1;
    wait_n(6);
    clrn <= 1'b1;
    wait_n(6);
  endtask : do_reset

  task automatic t_power_up;
    chk(48'(clamp), 48'h1);
    for (int c = 0; c < 4; c++) rchk(adr(c), 32'h0);
    rchk(QD_OFF_STATUS, 32'h0f);
    clrn <= 1'b0;
    wait_n(10);
    clrn <= 1'b1;
    wait_n(10);
    chk(48'(clamp), 48'h0);
    chk(48'(drv[0]), exp_drv(16'h0, 1'b0));
    ldn <= 1'b0;
  endtask : t_power_up

  task automatic t_write;
    fr(48'h147fff, 24);
    for (int c = 0; c < 4; c++) rchk(adr(c), 32'h7fff);
    fr(48'h11abcd, 24);
    rchk(adr(1), 32'habcd);
    chk(48'(drv[1]), exp_drv(16'habcd, 1'b0));
  endtask : t_write

  task automatic t_simul;
    ldn <= 1'b1;
    fr(48'h125555, 24);
    rchk(adr(2), 32'h7fff);
    ldn <= 1'b0;
    wait_n(10);
    rchk(adr(2), 32'h5555);
    chk(48'(drv[2]), exp_drv(16'h5555, 1'b0));
  endtask : t_simul

  task automatic t_bad;
    fr(48'h110000, 23);
    fr(48'h510000, 24);
    fr(48'h110000, 25);
    rchk(adr(1), 32'habcd);
    rchk(QD_OFF_STATUS, 32'h030e);
  endtask : t_bad

  task automatic t_read;
    logic [2:0] s;
    logic [15:0] m;
    for (int k = 0; k < 3; k++) begin
      s = 3'(k + 3);
      m = (k == 0) ? 16'h0003 : (k == 1) ? 16'h003f : 16'hffff;
      fr({26'h0, s, 3'h3, 16'hffff}, 24);
      fr({24'h0, 2'b10, s, 3'h3, 16'h0}, 24);
      fr(48'h0, 24);
      chk(48'(sq[23:0]), 48'({2'b10, s, 3'h3, m}));
    end
  endtask : t_read

  task automatic t_chain;
    fr(48'h110f0f_1200aa, 48);
    chk(48'(sq[23:0]), 48'h110f0f);
    rchk(adr(2), 32'h00aa);
    rchk(adr(1), 32'habcd);
  endtask : t_chain

  task automatic t_misc;
    fr(48'h040000, 24);
    for (int c = 0; c < 4; c++) rchk(adr(c), 32'h0);
    fr(48'h010001, 24);
    chk(48'(so_oe), 48'h0);
    fr(48'h010000, 24);
    chk(48'(so_oe), 48'h1);
    avs(1'b0, QD_OFF_CTRL, 32'h0);
    fr(48'h111111, 24);
    rchk(adr(1), 32'h0);
    rchk(5'h08, 32'h0);
    avs(1'b0, QD_OFF_CTRL, 32'h1);
    rchk(QD_OFF_CTRL, 32'h1);
    cod <= 1'b1;
    wait_n(10);
    chk(48'(drv[0]), exp_drv(16'h0, 1'b1));
    rchk(QD_OFF_STATUS, 32'h040c);
    // load strobe high so only the clear level can unclamp
    ldn <= 1'b1;
    do_reset(1'b1);
    chk(48'(clamp), 48'h1);
    rchk(adr(0), 32'h0);
    do_reset(1'b0);
    chk(48'(clamp), 48'h0);
  endtask : t_misc

  initial begin
    rst_b = 1'b0;
    ldn = 1'b1;
    clrn = 1'b1;
    cod = 1'b0;
    req = '0;
    err_total = 0;
    check_count = 0;
    wait_n(6);
    rst_b <= 1'b1;
    wait_n(6);
    t_power_up();
    t_write();
    t_simul();
    t_bad();
    t_read();
    t_chain();
    t_misc();
    complete_run();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    complete_run();
  end
endmodule : testbench
